// ==== include/pmx_pkg.sv ====
// Constants and helpers shared by the pin configuration and multiplexing block
`default_nettype none

package pmx_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  PMX_ADDR_PIN_TWO   = 8'h36;
  localparam logic [7:0]  PMX_ADDR_PIN_THREE = 8'h37;
  localparam int          PMX_ADDR_W         = 8;
  localparam int          PMX_DATA_W         = 16;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int          PMX_SEL_LSB        = 0;
  localparam int          PMX_SEL_MSB        = 2;
  localparam int          PMX_PD_BIT         = 3;
  localparam int          PMX_OUT_BIT        = 4;
  localparam int          PMX_IN_BIT         = 5;
  localparam logic [15:0] PMX_CFG_RESET      = 16'h0008;
  localparam logic [2:0]  PMX_SEL_RESET      = 3'h0;
  localparam logic        PMX_PD_RESET       = 1'b1;
  localparam logic        PMX_OUT_RESET      = 1'b0;

  // ****************************************************************
  // Function select codes
  // ****************************************************************
  localparam logic [2:0]  PMX_FN_HIZ         = 3'h0;
  localparam logic [2:0]  PMX_FN_OUT         = 3'h1;
  localparam logic [2:0]  PMX_FN_OUT_RB      = 3'h2;
  localparam logic [2:0]  PMX_FN_IN          = 3'h3;
  localparam logic [2:0]  PMX_FN_FET         = 3'h4;
  localparam logic [2:0]  PMX_FN_UART        = 3'h5;
  localparam logic [2:0]  PMX_FN_MON         = 3'h6;
  localparam logic [2:0]  PMX_FN_FLAG        = 3'h7;

  // UART lines idle high between characters
  localparam logic        PMX_UART_IDLE      = 1'b1;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] pmx_cfg_word(input logic [2:0] sel,
                                               input logic       pd,
                                               input logic       out_lvl,
                                               input logic       in_lvl);
    logic [15:0] w;
    w                           = 16'h0000;
    w[PMX_SEL_MSB:PMX_SEL_LSB]  = sel;
    w[PMX_PD_BIT]               = pd;
    w[PMX_OUT_BIT]              = out_lvl;
    w[PMX_IN_BIT]               = in_lvl;
    return w;
  endfunction : pmx_cfg_word

  function automatic logic pmx_hit(input logic [7:0] addr,
                                   input logic [7:0] target);
    return addr == target;
  endfunction : pmx_hit

endpackage : pmx_pkg

`default_nettype wire

// ==== rtl/pmx_pin_cell.sv ====
// One configurable pin: function decode, registered pad controls, input synchroniser
`timescale 1ns/1ps
`default_nettype none

module pmx_pin_cell
  import pmx_pkg::*;
#(
  parameter logic FN45_IS_INPUT = 1'b0
)
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [2:0] sel_i,
  input  wire logic       out_level_i,
  input  wire logic       pd_en_i,
  input  wire logic       pin_in_i,
  input  wire logic       fn4_src_i,
  input  wire logic       fn5_src_i,
  input  wire logic       fn6_src_i,
  input  wire logic       fn7_src_i,
  output logic            pin_out_o,
  output logic            pin_oe_o,
  output logic            pin_pd_o,
  output logic            level_o,
  output logic            in_data_o
);

  // ****************************************************************
  // Function decode
  // ****************************************************************
  wire       is_out   = (sel_i == PMX_FN_OUT) || (sel_i == PMX_FN_OUT_RB);
  wire       is_fn45  = (sel_i == PMX_FN_FET) || (sel_i == PMX_FN_UART);
  wire       is_drv7  = (sel_i == PMX_FN_MON) || (sel_i == PMX_FN_FLAG);
  // High impedance falls out of every term being false
  wire       oe_nxt   = is_out | (is_fn45 & ~FN45_IS_INPUT) | is_drv7;
  wire       ibuf_nxt = (sel_i == PMX_FN_OUT_RB) || (sel_i == PMX_FN_IN) ||
                        (is_fn45 & FN45_IS_INPUT);
  wire       out_nxt  = is_out                  ? out_level_i :
                        (sel_i == PMX_FN_FET)  ? fn4_src_i   :
                        (sel_i == PMX_FN_UART) ? fn5_src_i   :
                        (sel_i == PMX_FN_MON)  ? fn6_src_i   :
                        (sel_i == PMX_FN_FLAG) ? fn7_src_i   : 1'b0;

  logic       ibuf_r;
  logic [2:0] sync_r;
  logic       level_r;

  // Registered pad controls cannot glitch through other functions
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_out_o <= PMX_OUT_RESET;
      pin_oe_o  <= 1'b0;
      pin_pd_o  <= PMX_PD_RESET;
      ibuf_r    <= 1'b0;
    end
    else
    begin
      pin_out_o <= out_nxt & oe_nxt;
      pin_oe_o  <= oe_nxt;
      pin_pd_o  <= pd_en_i;
      ibuf_r    <= ibuf_nxt;
    end
  end

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  // Level accepted only once the second and third stages agree
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync_r    <= 3'h0;
      level_r   <= 1'b0;
      in_data_o <= 1'b0;
    end
    else
    begin
      sync_r    <= {sync_r[1:0], pin_in_i};
      if (sync_r[1] == sync_r[2])
      begin
        level_r <= sync_r[2];
      end
      in_data_o <= level_r & ibuf_r;
    end
  end

  assign level_o = level_r;

endmodule : pmx_pin_cell

`default_nettype wire

// ==== rtl/pmx_pin_mux.sv ====
// Configuration registers and function multiplexing for the second and third pins
`timescale 1ns/1ps
`default_nettype none

module pmx_pin_mux
  import pmx_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [15:0]      reg_rdata_o,
  output logic             reg_rd_valid_o,
  input  wire logic [2:0]  pin_one_sel_i,
  input  wire logic [2:0]  pin_four_sel_i,
  input  wire logic        pin_two_in_i,
  output logic             pin_two_out_o,
  output logic             pin_two_oe_o,
  output logic             pin_two_pd_o,
  input  wire logic        pin_three_in_i,
  output logic             pin_three_out_o,
  output logic             pin_three_oe_o,
  output logic             pin_three_pd_o,
  input  wire logic        ext_fet_ctrl_i,
  input  wire logic        modem_rxd_i,
  input  wire logic        modem_txd_mon_i,
  input  wire logic        message_start_flag_i,
  input  wire logic        tx_complete_flag_i,
  output logic             modem_txd_o,
  output logic             int_fet_drive_o,
  output logic             uart_pins_mode_o,
  output logic             spi_uart_path_en_o
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [2:0] two_sel_r;
  logic       two_pd_r;
  logic       two_out_r;
  logic [2:0] three_sel_r;
  logic       three_pd_r;
  logic       three_out_r;

  wire hit_two   = pmx_hit(reg_addr_i, PMX_ADDR_PIN_TWO);
  wire hit_three = pmx_hit(reg_addr_i, PMX_ADDR_PIN_THREE);
  wire wr_two    = reg_wr_i & hit_two;
  wire wr_three  = reg_wr_i & hit_three;

  // Bit 5 and bits 15:6 are never stored, so writes to them are dropped
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      two_sel_r   <= PMX_SEL_RESET;
      two_pd_r    <= PMX_PD_RESET;
      two_out_r   <= PMX_OUT_RESET;
      three_sel_r <= PMX_SEL_RESET;
      three_pd_r  <= PMX_PD_RESET;
      three_out_r <= PMX_OUT_RESET;
    end
    else
    begin
      if (wr_two)
      begin
        two_sel_r <= reg_wdata_i[PMX_SEL_MSB:PMX_SEL_LSB];
        two_pd_r  <= reg_wdata_i[PMX_PD_BIT];
        two_out_r <= reg_wdata_i[PMX_OUT_BIT];
      end
      if (wr_three)
      begin
        three_sel_r <= reg_wdata_i[PMX_SEL_MSB:PMX_SEL_LSB];
        three_pd_r  <= reg_wdata_i[PMX_PD_BIT];
        three_out_r <= reg_wdata_i[PMX_OUT_BIT];
      end
    end
  end

  // ****************************************************************
  // Pin cells
  // ****************************************************************
  logic two_in_data;
  logic three_lvl;
  logic three_in_data;

  // Second pin drives in every function 100..111
  pmx_pin_cell #(
    .FN45_IS_INPUT (1'b0)
  ) u_pin_two (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .sel_i       (two_sel_r),
    .out_level_i (two_out_r),
    .pd_en_i     (two_pd_r),
    .pin_in_i    (pin_two_in_i),
    .fn4_src_i   (ext_fet_ctrl_i),
    .fn5_src_i   (modem_rxd_i),
    .fn6_src_i   (modem_rxd_i),
    .fn7_src_i   (message_start_flag_i),
    .pin_out_o   (pin_two_out_o),
    .pin_oe_o    (pin_two_oe_o),
    .pin_pd_o    (pin_two_pd_o),
    .level_o     (),
    .in_data_o   (two_in_data)
  );

  // Third pin listens in 100 and 101
  pmx_pin_cell #(
    .FN45_IS_INPUT (1'b1)
  ) u_pin_three (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .sel_i       (three_sel_r),
    .out_level_i (three_out_r),
    .pd_en_i     (three_pd_r),
    .pin_in_i    (pin_three_in_i),
    .fn4_src_i   (1'b0),
    .fn5_src_i   (1'b0),
    .fn6_src_i   (modem_txd_mon_i),
    .fn7_src_i   (tx_complete_flag_i),
    .pin_out_o   (pin_three_out_o),
    .pin_oe_o    (pin_three_oe_o),
    .pin_pd_o    (pin_three_pd_o),
    .level_o     (three_lvl),
    .in_data_o   (three_in_data)
  );

  // ****************************************************************
  // Modem and transistor routing
  // ****************************************************************
  wire all_uart     = (pin_one_sel_i == PMX_FN_UART) && (two_sel_r == PMX_FN_UART) &&
                      (three_sel_r == PMX_FN_UART) && (pin_four_sel_i == PMX_FN_UART);
  wire txd_nxt      = (three_sel_r == PMX_FN_UART) ? three_lvl : PMX_UART_IDLE;
  wire int_fet_nxt  = (three_sel_r == PMX_FN_FET) & three_lvl;

  // Carrier detect lives on the first pin, outside this block
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      modem_txd_o        <= PMX_UART_IDLE;
      int_fet_drive_o    <= 1'b0;
      uart_pins_mode_o   <= 1'b0;
      spi_uart_path_en_o <= 1'b1;
    end
    else
    begin
      modem_txd_o        <= txd_nxt;
      int_fet_drive_o    <= int_fet_nxt;
      uart_pins_mode_o   <= all_uart;
      spi_uart_path_en_o <= ~all_uart;
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  wire [15:0] two_word   = pmx_cfg_word(two_sel_r, two_pd_r, two_out_r, two_in_data);
  wire [15:0] three_word = pmx_cfg_word(three_sel_r, three_pd_r, three_out_r, three_in_data);
  // Unmapped addresses answer zero rather than stale data
  wire [15:0] rd_mux     = hit_two   ? two_word   :
                           hit_three ? three_word : 16'h0000;

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reg_rdata_o    <= 16'h0000;
      reg_rd_valid_o <= 1'b0;
    end
    else
    begin
      reg_rd_valid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        reg_rdata_o <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_two_write_alone;
    wr_two ##1 !wr_two;
  endsequence

  sequence s_two_sel_held(logic [2:0] code);
    (two_sel_r == code) [*2];
  endsequence

  sequence s_three_sel_held(logic [2:0] code);
    (three_sel_r == code) [*2];
  endsequence

  property p_reset_state;
    @(posedge core_clk_i) $rose(rst_b_i) |->
      pin_two_pd_o && pin_three_pd_o && !pin_two_oe_o && !pin_three_oe_o;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("pins not high impedance with pull-down after reset");

  property p_pd_follows_write;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      s_two_write_alone |-> ##1 (pin_two_pd_o == $past(reg_wdata_i[PMX_PD_BIT], 2));
  endproperty
  a_pd_follows_write: assert property (p_pd_follows_write)
    else $error("pull-down did not follow its enable bit");

  property p_rb_zero_when_off;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      // Input data lags a select change by two flops
      ((two_sel_r == PMX_FN_OUT || two_sel_r == PMX_FN_HIZ) [*3]) ##0 (reg_rd_i && hit_two)
      |-> ##1 !reg_rdata_o[PMX_IN_BIT];
  endproperty
  a_rb_zero_when_off: assert property (p_rb_zero_when_off)
    else $error("input data bit set while input buffer disabled");

  property p_reserved_zero;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      reg_rd_valid_o |-> (reg_rdata_o[15:6] == 10'h000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read non-zero");

  property p_hiz;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      s_two_sel_held(PMX_FN_HIZ) |-> !pin_two_oe_o && !pin_two_out_o;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("second pin driven in high impedance function");

  property p_out_level;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      s_two_sel_held(PMX_FN_OUT) |-> pin_two_oe_o && (pin_two_out_o == $past(two_out_r));
  endproperty
  a_out_level: assert property (p_out_level)
    else $error("second pin not driving its output level");

  property p_three_input;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      s_three_sel_held(PMX_FN_IN) |-> !pin_three_oe_o;
  endproperty
  a_three_input: assert property (p_three_input)
    else $error("third pin driven in input function");

  property p_rxd_out;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      s_two_sel_held(PMX_FN_UART) |-> pin_two_oe_o && (pin_two_out_o == $past(modem_rxd_i));
  endproperty
  a_rxd_out: assert property (p_rxd_out)
    else $error("second pin not carrying received data");

  property p_tx_complete;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      s_three_sel_held(PMX_FN_FLAG) |->
        pin_three_oe_o && (pin_three_out_o == $past(tx_complete_flag_i));
  endproperty
  a_tx_complete: assert property (p_tx_complete)
    else $error("third pin not carrying transmit-complete flag");

  property p_txd_forward;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      s_three_sel_held(PMX_FN_UART) |-> !pin_three_oe_o && (modem_txd_o == $past(three_lvl));
  endproperty
  a_txd_forward: assert property (p_txd_forward)
    else $error("transmit data not forwarded from third pin");

  property p_uart_mode;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      all_uart [*2] |-> uart_pins_mode_o && !spi_uart_path_en_o;
  endproperty
  a_uart_mode: assert property (p_uart_mode)
    else $error("serial UART path not disabled in four-pin mode");

  property p_som_flag;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      s_two_sel_held(PMX_FN_FLAG) |->
        pin_two_oe_o && (pin_two_out_o == $past(message_start_flag_i));
  endproperty
  a_som_flag: assert property (p_som_flag)
    else $error("second pin not carrying message-start flag");

endmodule : pmx_pin_mux

`default_nettype wire

// ==== dv/pmx_host_model.sv ====
// Host-side model of one pad: resolves the wire level seen by the pin input
`timescale 1ns/1ps
`default_nettype none

module pmx_host_model
(
  input  wire logic core_clk_i,
  input  wire logic pin_out_i,
  input  wire logic pin_oe_i,
  input  wire logic pin_pd_i,
  input  wire logic host_en_i,
  input  wire logic host_val_i,
  output logic      pin_level_o
);
  // ****************************************************************
  // Wire resolution
  // ****************************************************************
  logic last_r = 1'b0;

  always_ff @(posedge core_clk_i)
  begin
    last_r <= pin_level_o;
  end

  // Undriven pad without pull-down toggles so a stale level cannot pass
  assign pin_level_o = pin_oe_i  ? pin_out_i  :
                       host_en_i ? host_val_i :
                       pin_pd_i  ? 1'b0       :
                       ~last_r;
endmodule : pmx_host_model

`default_nettype wire

// ==== dv/pin_mux_config_b_c_bench.sv ====
// Self-checking bench for the second and third pin configuration block
`timescale 1ns/1ps
`default_nettype none

module pin_mux_config_b_c_bench
  import pmx_pkg::*;
;
  logic        core_clk;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        reg_rd_valid;
  logic [2:0]  pin_one_sel;
  logic [2:0]  pin_four_sel;
  logic        two_in, two_out, two_oe, two_pd;
  logic        three_in, three_out, three_oe, three_pd;
  logic        ext_fet, rxd, txd_mon, msg_flag, txc_flag;
  logic        modem_txd, int_fet, uart_mode, spi_en;
  logic        host_en [2];
  logic        host_val [2];
  logic        cur;
  int          errors;
  int          cmp_count;

  wire logic   p_oe  = cur ? three_oe : two_oe;
  wire logic   p_out = cur ? three_out : two_out;

  pmx_pin_mux pmx_pin_mux_inst (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .reg_rd_valid_o(reg_rd_valid), .pin_one_sel_i(pin_one_sel), .pin_four_sel_i(pin_four_sel),
    .pin_two_in_i(two_in), .pin_two_out_o(two_out), .pin_two_oe_o(two_oe),
    .pin_two_pd_o(two_pd), .pin_three_in_i(three_in), .pin_three_out_o(three_out),
    .pin_three_oe_o(three_oe), .pin_three_pd_o(three_pd), .ext_fet_ctrl_i(ext_fet),
    .modem_rxd_i(rxd), .modem_txd_mon_i(txd_mon), .message_start_flag_i(msg_flag),
    .tx_complete_flag_i(txc_flag), .modem_txd_o(modem_txd), .int_fet_drive_o(int_fet),
    .uart_pins_mode_o(uart_mode), .spi_uart_path_en_o(spi_en));

  pmx_host_model pmx_host_model_inst (
    .core_clk_i(core_clk), .pin_out_i(two_out), .pin_oe_i(two_oe), .pin_pd_i(two_pd),
    .host_en_i(host_en[0]), .host_val_i(host_val[0]), .pin_level_o(two_in));

  pmx_host_model pmx_host_model_three_inst (
    .core_clk_i(core_clk), .pin_out_i(three_out), .pin_oe_i(three_oe), .pin_pd_i(three_pd),
    .host_en_i(host_en[1]), .host_val_i(host_val[1]), .pin_level_o(three_in));

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp, input string what);
    chk16({15'h0000, got}, {15'h0000, exp}, what);
  endtask : chk1

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    // Valid stands for one cycle only, so look before the next edge
    chk1(reg_rd_valid, 1'b1, "read valid");
    chk16(reg_rdata, exp, "read data");
    reg_rd   = 1'b0;
  endtask : rd_chk

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd_chk(PMX_ADDR_PIN_TWO, 16'h0008);
    rd_chk(PMX_ADDR_PIN_THREE, 16'h0008);
    chk1(two_pd & three_pd, 1'b1, "pull-down after reset");
    chk1(two_oe | three_oe, 1'b0, "driver off after reset");
    chk1(spi_en & ~uart_mode, 1'b1, "serial path after reset");
    chk1(modem_txd & ~int_fet, 1'b1, "modem line idle after reset");
  endtask : t_reset

  task automatic t_pulldown();
    host_en[0]  = 1'b1;
    host_val[0] = 1'b1;
    wr(PMX_ADDR_PIN_TWO, 16'h0000);
    idle(2);
    chk1(two_pd, 1'b0, "pull-down removed");
    idle(8);
    rd_chk(PMX_ADDR_PIN_TWO, 16'h0000);
    chk1(two_oe, 1'b0, "hi-z driver off");
    host_en[0] = 1'b0;
    wr(PMX_ADDR_PIN_TWO, 16'h0008);
    idle(2);
    chk1(two_pd, 1'b1, "pull-down restored");
  endtask : t_pulldown

  task automatic t_gpio();
    logic [7:0] a;
    for (int k = 0; k < 2; k++)
    begin
      cur = k[0];
      a   = k ? PMX_ADDR_PIN_THREE : PMX_ADDR_PIN_TWO;
      wr(a, 16'h0011);
      idle(2);
      chk1(p_oe & p_out, 1'b1, "output high");
      rd_chk(a, 16'h0011);
      wr(a, 16'h0001);
      idle(2);
      chk1(p_out, 1'b0, "output low");
      wr(a, 16'h0012);
      idle(8);
      rd_chk(a, 16'h0032);
      host_en[k]  = 1'b1;
      host_val[k] = 1'b1;
      wr(a, 16'h0003);
      idle(8);
      chk1(p_oe, 1'b0, "input driver off");
      rd_chk(a, 16'h0023);
      host_val[k] = 1'b0;
      wr(a, 16'hFFE3);
      idle(8);
      rd_chk(a, 16'h0003);
      host_en[k] = 1'b0;
      wr(a, 16'h0008);
    end
  endtask : t_gpio

  task automatic t_pin_two();
    cur = 1'b0;
    for (int s = 4; s < 8; s++)
    begin
      for (int v = 0; v < 2; v++)
      begin
        ext_fet  = (s == 4) ? v[0] : ~v[0];
        rxd      = (s == 5 || s == 6) ? v[0] : ~v[0];
        msg_flag = (s == 7) ? v[0] : ~v[0];
        wr(PMX_ADDR_PIN_TWO, {13'h0000, s[2:0]});
        idle(8);
        chk1(two_oe, 1'b1, "pin two driving");
        chk1(two_out, v[0], "pin two source");
        rd_chk(PMX_ADDR_PIN_TWO, {13'h0000, s[2:0]});
      end
    end
  endtask : t_pin_two

  task automatic t_pin_three();
    cur        = 1'b1;
    host_en[1] = 1'b1;
    for (int s = 4; s < 8; s++)
    begin
      for (int v = 0; v < 2; v++)
      begin
        host_en[1]  = (s < 6);
        host_val[1] = v[0];
        txd_mon     = (s == 6) ? v[0] : ~v[0];
        txc_flag    = (s == 7) ? v[0] : ~v[0];
        wr(PMX_ADDR_PIN_THREE, {13'h0000, s[2:0]});
        idle(8);
        chk1(three_oe, s > 5, "pin three direction");
        if (s == 4)
          chk1(int_fet, v[0], "internal transistor drive");
        if (s == 5)
          chk1(modem_txd, v[0], "modem transmit data");
        if (s > 5)
          chk1(three_out, v[0], "pin three source");
        rd_chk(PMX_ADDR_PIN_THREE, {10'h000, (s < 6) & v[0], 2'h0, s[2:0]});
      end
    end
    host_en[1] = 1'b0;
  endtask : t_pin_three

  task automatic t_uart();
    wr(PMX_ADDR_PIN_TWO, 16'h0005);
    wr(PMX_ADDR_PIN_THREE, 16'h0005);
    pin_one_sel  = PMX_FN_UART;
    pin_four_sel = PMX_FN_UART;
    idle(3);
    chk1(uart_mode & ~spi_en, 1'b1, "four-pin modem mode");
    pin_four_sel = PMX_FN_FET;
    idle(3);
    chk1(~uart_mode & spi_en, 1'b1, "serial path back");
    wr(8'h38, 16'hFFFF);
    rd_chk(8'h38, 16'h0000);
    rd_chk(PMX_ADDR_PIN_TWO, 16'h0005);
  endtask : t_uart

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Clock, reset, sequence and watchdog
  // ****************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial
  begin
    {errors, cmp_count} = {32'h0, 32'h0};
    {rst_b, reg_wr, reg_rd, cur} = 4'h0;
    {reg_addr, reg_wdata, pin_one_sel, pin_four_sel} = 30'h0;
    {ext_fet, rxd, txd_mon, msg_flag, txc_flag} = 5'h0;
    host_en  = '{1'b0, 1'b0};
    host_val = '{1'b0, 1'b0};
    idle(5);
    rst_b = 1'b1;
    t_reset();
    t_pulldown();
    t_gpio();
    t_pin_two();
    t_pin_three();
    t_uart();
    end_of_test();
  end

  // Whole run needs well under 1000 cycles
  initial
  begin
    #20000;
    errors++;
    end_of_test();
  end
endmodule : pin_mux_config_b_c_bench

`default_nettype wire
